// ---- common/acp_pkg.sv ----
/*
 * Shared constants and types for the two-wire A/D conversion port.
 * Assumes a 200 MHz system clock and an analog core that delivers
 * one right-justified result word per conversion.
 */
package acp_pkg;

    // clock and resolution-reduction window
    localparam int ACP_CLK_MHZ      = 200;
    localparam int ACP_WIN_US       = 1000;
    localparam int ACP_WIN_CYC      = ACP_WIN_US * ACP_CLK_MHZ;

    // resolution
    localparam int ACP_RES_MAX      = 16;
    localparam int ACP_MAX_REDUCE   = 6;
    localparam int ACP_RES_W        = 5;
    localparam int ACP_RED_W        = 3;

    // result buffer
    localparam int ACP_FIFO_DEPTH   = 16;

    // channel select codes, upper bit first
    localparam logic [1:0] ACP_SEL_IN1 = 2'h0;
    localparam logic [1:0] ACP_SEL_IN2 = 2'h1;
    localparam logic [1:0] ACP_SEL_IN3 = 2'h2;
    localparam logic [1:0] ACP_SEL_IN4 = 2'h3;

    // one-hot input routes, plus the all-zero no-route value
    localparam logic [3:0] ACP_ROUTE_IN1 = 4'h1;
    localparam logic [3:0] ACP_ROUTE_IN2 = 4'h2;
    localparam logic [3:0] ACP_ROUTE_IN3 = 4'h4;
    localparam logic [3:0] ACP_ROUTE_IN4 = 4'h8;
    localparam logic [3:0] ACP_ROUTE_NONE = 4'h0;

    // data line levels
    localparam logic ACP_LINE_HIGH = 1'b1;
    localparam logic ACP_LINE_LOW  = 1'b0;

    typedef enum logic [1:0] {
        ST_SLEEP,
        ST_WINDOW,
        ST_CONVERT
    } acp_state_t;

endpackage : acp_pkg

// ---- rtl/acp_port.sv ----
/*
 * Two-wire conversion port: result buffer and port controller.
 * Assumes the serial clock and channel pins are asynchronous to
 * sys_clk_i, and that the analog core reads acp_chan_route_o and
 * acp_res_bits_o and pushes a right-justified result word when done.
 */
`timescale 1ns/1ps


module acp_fifo
    import acp_pkg::*;
#(
    parameter int W = ACP_RES_MAX,
    parameter int D = ACP_FIFO_DEPTH
)(
    // clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    // fill side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // drain side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wp;
        logic [PW-1:0]       rp;
        logic [CW-1:0]       cnt;
        logic                rdy;
    } acp_fifo_st_t;

    acp_fifo_st_t r;
    acp_fifo_st_t n;
    logic         push;
    logic         pop;

    always_comb
    begin
        n    = r;
        push = in_valid_i && r.rdy;
        pop  = out_ready_i && (r.cnt != '0);
        if (push)
        begin
            n.mem[r.wp] = in_data_i;
            n.wp        = (r.wp == PW'(D - 1)) ? '0 : PW'(r.wp + 1'b1);
        end
        if (pop)
        begin
            n.rp = (r.rp == PW'(D - 1)) ? '0 : PW'(r.rp + 1'b1);
        end
        if (push && !pop)
        begin
            n.cnt = CW'(r.cnt + 1'b1);
        end
        else if (pop && !push)
        begin
            n.cnt = CW'(r.cnt - 1'b1);
        end
        n.rdy = (n.cnt != CW'(D));
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            r     <= '0;
            r.rdy <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    assign in_ready_o  = r.rdy;
    assign out_valid_o = (r.cnt != '0);
    assign out_data_o  = r.mem[r.rp];

endmodule : acp_fifo

module acp_port
    import acp_pkg::*;
#(
    parameter int RES_WIN_CYC = ACP_WIN_CYC,
    parameter int FIFO_DEPTH  = ACP_FIFO_DEPTH
)(
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_i,
    // two-wire link pins
    input  wire logic                   ser_clk_i,
    input  wire logic                   chan_sel_hi_i,
    input  wire logic                   chan_sel_lo_i,
    output logic                        serial_result_out_o,
    // analog core control
    output logic                        acp_conv_start_o,
    output logic [3:0]                  acp_chan_route_o,
    output logic [ACP_RES_W-1:0]        acp_res_bits_o,
    // analog core result
    input  wire logic                   result_valid_i,
    input  wire logic [ACP_RES_MAX-1:0] result_data_i,
    output logic                        result_ready_o
);
    localparam int WW = $clog2(RES_WIN_CYC);

    typedef struct packed {
        acp_state_t             st;
        logic                   clk_m;
        logic                   clk_s;
        logic                   clk_p;
        logic [1:0]             sel_m;
        logic [1:0]             sel_s;
        logic [1:0]             sel;
        logic [3:0]             route;
        logic [ACP_RED_W-1:0]   reduce;
        logic [ACP_RES_W-1:0]   res;
        logic [WW-1:0]          win;
        logic                   ack;
        logic                   serial_result_out;
        logic [ACP_RES_MAX-1:0] shreg;
        logic [ACP_RES_W-1:0]   left;
        logic                   start;
    } acp_port_st_t;

    acp_port_st_t           r;
    acp_port_st_t           n;
    logic                   fall;
    logic                   rise;
    logic                   win_end;
    logic                   pop;
    logic                   fifo_valid;
    logic [ACP_RES_MAX-1:0] fifo_data;

    acp_fifo #(
        .W (ACP_RES_MAX),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (result_valid_i),
        .in_data_i   (result_data_i),
        .in_ready_o  (result_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (pop)
    );

    function automatic logic [3:0] route_of(input logic [1:0] sel);
        case (sel)
            ACP_SEL_IN1: route_of = ACP_ROUTE_IN1;
            ACP_SEL_IN2: route_of = ACP_ROUTE_IN2;
            ACP_SEL_IN3: route_of = ACP_ROUTE_IN3;
            ACP_SEL_IN4: route_of = ACP_ROUTE_IN4;
            default:     route_of = ACP_ROUTE_NONE;
        endcase
    endfunction : route_of

    always_comb
    begin
        n       = r;
        n.start = 1'b0;
        n.clk_m = ser_clk_i;
        n.clk_s = r.clk_m;
        n.clk_p = r.clk_s;
        n.sel_m = {chan_sel_hi_i, chan_sel_lo_i};
        n.sel_s = r.sel_m;
        fall    = r.clk_p && !r.clk_s;
        rise    = !r.clk_p && r.clk_s;
        win_end = (r.win == WW'(RES_WIN_CYC - 1));
        pop     = 1'b0;
        case (r.st)
            ST_SLEEP:
            begin
                if (fall && (r.left != '0))
                begin
                    n.serial_result_out  = r.shreg[ACP_RES_MAX-1];
                    n.shreg = r.shreg << 1;
                    n.left  = ACP_RES_W'(r.left - 1'b1);
                end
                else if (fall)
                begin
                    n.st     = ST_WINDOW;
                    n.start  = 1'b1;
                    n.sel    = r.sel_s;
                    n.route  = route_of(r.sel_s);
                    n.reduce = '0;
                    n.res    = ACP_RES_W'(ACP_RES_MAX);
                    n.win    = '0;
                    n.ack    = 1'b0;
                    n.serial_result_out   = ACP_LINE_LOW;
                end
            end
            ST_WINDOW:
            begin
                n.win = WW'(r.win + 1'b1);
                if (fall && (r.reduce < ACP_RED_W'(ACP_MAX_REDUCE)))
                begin
                    n.reduce = ACP_RED_W'(r.reduce + 1'b1);
                    n.res    = ACP_RES_W'(r.res - 1'b1);
                    n.ack    = 1'b1;
                    n.serial_result_out   = ACP_LINE_HIGH;
                end
                if (rise && r.ack)
                begin
                    n.ack  = 1'b0;
                    n.serial_result_out = ACP_LINE_LOW;
                end
                if (win_end)
                begin
                    n.st   = ST_CONVERT;
                    n.ack  = 1'b0;
                    n.serial_result_out = ACP_LINE_LOW;
                end
            end
            ST_CONVERT:
            begin
                n.serial_result_out = ACP_LINE_LOW;
                if (fifo_valid)
                begin
                    pop     = 1'b1;
                    n.shreg = fifo_data << (ACP_RES_W'(ACP_RES_MAX) - r.res);
                    n.left  = r.res;
                    n.serial_result_out  = ACP_LINE_HIGH;
                    n.st    = ST_SLEEP;
                end
            end
            default:
            begin
                n.st   = ST_SLEEP;
                n.serial_result_out = ACP_LINE_HIGH;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            r       <= '0;
            r.st    <= ST_SLEEP;
            r.clk_m <= ACP_LINE_HIGH;
            r.clk_s <= ACP_LINE_HIGH;
            r.clk_p <= ACP_LINE_HIGH;
            r.res   <= ACP_RES_W'(ACP_RES_MAX);
            r.serial_result_out  <= ACP_LINE_HIGH;
        end
        else
        begin
            r <= n;
        end
    end

    assign serial_result_out_o = r.serial_result_out;
    assign acp_conv_start_o    = r.start;
    assign acp_chan_route_o    = r.route;
    assign acp_res_bits_o      = r.res;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_start_wake: assert property ((r.st == ST_SLEEP) && fall && (r.left == '0)
        |=> (r.st == ST_WINDOW) && r.start && !r.serial_result_out ##1 !r.start)
        else $error("falling edge in sleep did not start conversion");
    a_sel_latch: assert property ((r.st == ST_SLEEP) && fall && (r.left == '0)
        |=> (r.sel == $past(r.sel_s)))
        else $error("channel select not latched at start edge");
    a_route_map: assert property ((r.st == ST_WINDOW)
        |-> (r.route == (ACP_ROUTE_IN1 << r.sel)))
        else $error("select code routes wrong input");
    a_reduce_step: assert property ((r.st == ST_WINDOW) && fall
        && (r.reduce < ACP_RED_W'(ACP_MAX_REDUCE))
        |=> (r.res == ACP_RES_W'($past(r.res) - 1'b1)))
        else $error("window edge did not lower resolution");
    a_reduce_floor: assert property (r.res >= ACP_RES_W'(ACP_RES_MAX - ACP_MAX_REDUCE))
        else $error("resolution dropped below floor");
    a_busy_low: assert property ((r.st == ST_CONVERT) |-> !r.serial_result_out)
        else $error("data line not low during conversion");
    a_ack_high: assert property ((r.st == ST_WINDOW) && fall && !win_end
        && (r.reduce < ACP_RED_W'(ACP_MAX_REDUCE)) |=> r.serial_result_out && r.ack)
        else $error("reduction edge not acknowledged");
    a_ack_drop: assert property ((r.st == ST_WINDOW) && r.ack && (rise || win_end)
        |=> !r.serial_result_out)
        else $error("acknowledge not withdrawn");
    a_done_high: assert property ((r.st == ST_CONVERT) && fifo_valid
        |=> (r.st == ST_SLEEP) && r.serial_result_out && (r.left == $past(r.res)))
        else $error("completion not signalled high");
    a_shift_msb: assert property ((r.st == ST_SLEEP) && fall && (r.left != '0)
        |=> (r.serial_result_out == $past(r.shreg[ACP_RES_MAX-1])))
        else $error("readout bit not msb of remaining word");
    a_win_len: assert property ($rose(r.st == ST_CONVERT)
        |-> ($past(r.win) == WW'(RES_WIN_CYC - 1)))
        else $error("window length wrong");

    c_start: cover property ((r.st == ST_SLEEP) && fall && (r.left == '0));
    c_floor: cover property (r.res == ACP_RES_W'(ACP_RES_MAX - ACP_MAX_REDUCE));
    c_done: cover property ((r.st == ST_CONVERT) && fifo_valid);
    c_last_bit: cover property ((r.st == ST_SLEEP) && fall && (r.left == ACP_RES_W'(1)));

endmodule : acp_port

// ---- sim/acp_host_model.sv ----
/*
 * Host stand-in for the two-wire link: drives serial clock and select.
 * Assumes callers start each pulse off the system clock edges.
 */
`timescale 1ns/1ps

module acp_host_model (
    // link pins
    input  wire logic data_i,
    output logic      ser_clk_o,
    output logic      sel_hi_o,
    output logic      sel_lo_o
);
    // clock idles high between frames
    initial
    begin
        ser_clk_o = 1'b1;
        sel_hi_o  = 1'b0;
        sel_lo_o  = 1'b0;
    end

    task automatic set_sel(input logic [1:0] sel);
        {sel_hi_o, sel_lo_o} = sel;
    endtask : set_sel

    task automatic pulse(output logic lo_smp, output logic hi_smp);
        ser_clk_o = 1'b0;
        #30;
        lo_smp = data_i;
        #2;
        ser_clk_o = 1'b1;
        #30;
        hi_smp = data_i;
        #2;
    endtask : pulse
endmodule : acp_host_model

// ---- sim/tb_top.sv ----
/*
 * Self-checking bench for acp_port: host model plus core stand-in.
 * Assumes a short window parameter and a 16 word result buffer.
 */
`timescale 1ns/1ps

module tb_top;
    import acp_pkg::*;
    localparam int WIN = 200;
    logic                 sys_clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic                 ser_clk, sel_hi, sel_lo, data_o, start_o, rvalid, rready;
    logic [3:0]           route;
    logic [ACP_RES_W-1:0] res;
    logic [15:0]          rdata, lfsr_r;
    logic [15:0]          words[$];
    int                   fails = 0;
    int                   total_checks = 0;
    int                   starts = 0;
    int                   nf_tab[4] = '{0, 6, 7, 3};

    initial
    begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i)
        if (start_o === 1'b1)
            starts++;

    acp_port #(.RES_WIN_CYC(WIN), .FIFO_DEPTH(ACP_FIFO_DEPTH)) DUT (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ser_clk_i(ser_clk),
        .chan_sel_hi_i(sel_hi), .chan_sel_lo_i(sel_lo), .serial_result_out_o(data_o),
        .acp_conv_start_o(start_o), .acp_chan_route_o(route), .acp_res_bits_o(res),
        .result_valid_i(rvalid), .result_data_i(rdata), .result_ready_o(rready));

    acp_host_model host (.data_i(data_o), .ser_clk_o(ser_clk), .sel_hi_o(sel_hi),
        .sel_lo_o(sel_lo));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [3:0] exp_route(input logic [1:0] sel);
        return ACP_ROUTE_IN1 << sel;
    endfunction : exp_route

    // six window edges at most take effect
    function automatic int exp_res(input int nf);
        return ACP_RES_MAX - ((nf > ACP_MAX_REDUCE) ? ACP_MAX_REDUCE : nf);
    endfunction : exp_res

    task automatic chk_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s line %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic push(input logic [15:0] w);
        int n;
        n = 0;
        @(negedge sys_clk_i);
        rvalid = 1'b1;
        rdata  = w;
        @(posedge sys_clk_i);
        while (rready !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        chk_bit(1'(n < 50), 1'b1, "push stuck");
        words.push_back(w);
        @(negedge sys_clk_i);
        rvalid = 1'b0;
    endtask : push

    task automatic conv(input logic [1:0] sel, input int nf, input bit push_new);
        logic        lo, hi;
        logic [15:0] w;
        int          eff, s0, n;
        eff = (nf > ACP_MAX_REDUCE) ? ACP_MAX_REDUCE : nf;
        s0  = starts;
        n   = 0;
        @(negedge sys_clk_i);
        #1.3;
        host.set_sel(sel);
        #32;
        host.pulse(lo, hi);
        host.set_sel(~sel);
        chk_bit(lo, 1'b0, "busy start");
        chk_bit(hi, 1'b0, "busy high phase");
        chk(16'(route), 16'(exp_route(sel)), "route");
        chk(16'(starts - s0), 16'h0001, "start pulse");
        for (int i = 1; i <= nf; i++)
        begin
            host.pulse(lo, hi);
            chk_bit(lo, 1'(i <= ACP_MAX_REDUCE), "ack");
            chk_bit(hi, 1'b0, "ack release");
        end
        #(WIN * 5 + 60 - 64 * (nf + 1));
        chk(16'(res), 16'(exp_res(nf)), "resolution");
        if (push_new)
        begin
            chk_bit(data_o, 1'b0, "busy convert");
            lfsr_r = lfsr_next(lfsr_r);
            push(lfsr_r);
        end
        while (data_o !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        chk_bit(data_o, 1'b1, "done high");
        w = words.pop_front();
        @(negedge sys_clk_i);
        #1.3;
        for (int b = ACP_RES_MAX - eff - 1; b >= 0; b--)
        begin
            host.pulse(lo, hi);
            chk_bit(lo, w[b], "result bit");
            chk_bit(hi, w[b], "bit hold");
        end
    endtask : conv

    initial
    begin
        rvalid = 1'b0;
        rdata  = 16'h0000;
        lfsr_r = 16'h0024;
        repeat (4) @(negedge sys_clk_i);
        rst_i = 1'b0;
        chk(16'(res), 16'(exp_res(0)), "reset res");
        chk_bit(data_o, 1'b1, "idle high");
        for (int k = 0; k < 4; k++)
            conv(2'(k), nf_tab[k], 1'b1);
        for (int k = 0; k < ACP_FIFO_DEPTH; k++)
        begin
            lfsr_r = lfsr_next(lfsr_r);
            push(lfsr_r);
        end
        repeat (2) @(negedge sys_clk_i);
        chk_bit(rready, 1'b0, "buffer full");
        for (int k = 0; k < ACP_FIFO_DEPTH; k++)
        begin
            lfsr_r = lfsr_next(lfsr_r);
            conv(lfsr_r[1:0], int'(lfsr_r[4:2]), 1'b0);
        end
        chk_bit(rready, 1'b1, "buffer drained");
        final_report();
    end

    initial
    begin
        #300000;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end
endmodule : tb_top
